/* prf_pkg.sv */
package prf_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int unsigned PRF_HOST_LED_W = 4;
   localparam int unsigned PRF_STRAP_W = 4;
   // ****************************************
   // Field positions of the forwarded host LED bus
   // ****************************************
   localparam int unsigned PRF_LED_LINK_POS = 0;
   localparam int unsigned PRF_LED_10M_POS = 1;
   localparam int unsigned PRF_LED_100M_POS = 2;
   localparam int unsigned PRF_LED_1000M_POS = 3;
   // ****************************************
   // Reset and dark levels
   // ****************************************
   localparam logic PRF_LED_N_DARK = 1'h1;
   localparam logic PRF_LED_DARK = 1'h0;
   localparam logic [3:0] PRF_STRAP_RST = 4'h0;
   localparam logic PRF_HOLD_RST = 1'h1;
   localparam logic PRF_PDOWN_RST = 1'h0;
   localparam logic PRF_LVL_RST = 1'h0;
   typedef logic [PRF_STRAP_W-1:0] prf_strap_t;
endpackage : prf_pkg

/* prf_ctl_if.sv */
`timescale 1ns/1ps
interface prf_ctl_if;
   logic hold_reset;
   logic power_down;
   logic strap_capture;
   modport source (output hold_reset, output power_down, output strap_capture);
   modport sink (input hold_reset, input power_down, input strap_capture);
endinterface : prf_ctl_if

/* prf_rst_ctl.sv */
`timescale 1ns/1ps
module prf_rst_ctl
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic supply_ok_in,
   input wire logic device_reset_low_in,
   input wire logic sleep_request_in,
   prf_ctl_if.source ctl
);
   import prf_pkg::*;

   // ****************************************
   // Pin synchronisers: ok, reset_low, sleep
   // ****************************************
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic [2:0] last_ff;
   logic hold_ff;
   logic pdown_ff;
   logic capt_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= 3'h0;
         sync_ff <= 3'h0;
         last_ff <= 3'h0;
      end else begin
         meta_ff <= {sleep_request_in, device_reset_low_in, supply_ok_in};
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   wire ok_w = sync_ff[0];
   wire rst_low_w = sync_ff[1];
   wire sleep_w = sync_ff[2];
   wire nxt_hold = !ok_w || !rst_low_w;
   wire nxt_pdown = sleep_w && !nxt_hold;
   // Each release event alone is enough; two at once give one capture
   wire ok_rise_w = ok_w && !last_ff[0];
   wire rst_rise_w = rst_low_w && !last_ff[1];
   wire sleep_fall_w = !sleep_w && last_ff[2];
   wire nxt_capt = ok_rise_w || rst_rise_w || sleep_fall_w;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hold_ff <= PRF_HOLD_RST;
         pdown_ff <= PRF_PDOWN_RST;
         capt_ff <= PRF_LVL_RST;
      end else begin
         hold_ff <= nxt_hold;
         pdown_ff <= nxt_pdown;
         capt_ff <= nxt_capt;
      end
   end

   assign ctl.hold_reset = hold_ff;
   assign ctl.power_down = pdown_ff;
   assign ctl.strap_capture = capt_ff;

   // ****************************************
   // Checks
   // ****************************************
   hold_on_bad_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !sync_ff[0] |=> hold_ff)
      else $error("supply low did not hold reset");
   hold_on_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !sync_ff[1] |=> hold_ff)
      else $error("reset pin low did not hold reset");
   sleep_pdown_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (sync_ff == 3'h7) |=> pdown_ff && !hold_ff)
      else $error("sleep did not power down");
   capt_event_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(sync_ff[0]) || $rose(sync_ff[1]) || $fell(sync_ff[2]) |=> capt_ff)
      else $error("release event missed strap capture");
endmodule : prf_rst_ctl

/* prf_led_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - Reset pin low resets the device, PHY and serial link logic included.
// - Sleep input powers down PHY and serial link of both ports together.
// - Link, 10M, 100M, 1000M LEDs follow host port 0 LED signals 0 to 3.
// - Duplex LED lights while port A PHY runs full duplex.
// - Transmit LED lights while port A PHY transmits a packet.
// - Receive LED lights while port A PHY receives a packet.
// - Receive LED pin can instead output a clock for conformance testing.
// - Four address straps latched as bits 4:1 on supply rise or release.
module prf_led_top
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic supply_ok_in,
   input wire logic device_reset_low_in,
   input wire logic sleep_request_in,
   input wire logic [prf_pkg::PRF_HOST_LED_W-1:0] host_led_n_in,
   input wire logic phy_full_duplex_in,
   input wire logic phy_transmit_in,
   input wire logic phy_receive_in,
   input wire logic clock_view_en_in,
   input wire logic [prf_pkg::PRF_STRAP_W-1:0] mgmt_addr_strap_in,
   output logic port_a_link_led_n,
   output logic port_a_10m_led_n,
   output logic port_a_100m_led_n,
   output logic port_a_1000m_led_n,
   output logic port_a_full_duplex_led,
   output logic port_a_transmit_led,
   output logic port_a_receive_led,
   output logic phy_hold_reset,
   output logic phy_power_down,
   output logic [prf_pkg::PRF_STRAP_W-1:0] mgmt_addr_bits_4_1
);
   import prf_pkg::*;

   localparam int unsigned SYNC_W = PRF_HOST_LED_W + PRF_STRAP_W + 4;

   // ****************************************
   // Reset and sleep control
   // ****************************************
   prf_ctl_if ctl_if ();

   prf_rst_ctl u_rst_ctl (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .supply_ok_in(supply_ok_in),
      .device_reset_low_in(device_reset_low_in),
      .sleep_request_in(sleep_request_in),
      .ctl(ctl_if.source)
   );

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Straps pass the same two stages as the control pins so a capture
   // samples them in step with the release that caused it.
   logic [SYNC_W-1:0] meta_ff;
   logic [SYNC_W-1:0] sync_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {mgmt_addr_strap_in, clock_view_en_in, phy_receive_in, phy_transmit_in,
                     phy_full_duplex_in, host_led_n_in};
         sync_ff <= meta_ff;
      end
   end

   // Host LED levels pass through uninverted: a low from the host lights the LED
   wire [PRF_HOST_LED_W-1:0] host_led_n_w = sync_ff[PRF_HOST_LED_W-1:0];
   wire duplex_w = sync_ff[PRF_HOST_LED_W];
   wire transmit_w = sync_ff[PRF_HOST_LED_W+1];
   wire receive_w = sync_ff[PRF_HOST_LED_W+2];
   wire cview_en_w = sync_ff[PRF_HOST_LED_W+3];
   wire [PRF_STRAP_W-1:0] strap_w = sync_ff[SYNC_W-1:PRF_HOST_LED_W+4];

   // ****************************************
   // LED selection
   // ****************************************
   logic link_n_ff;
   logic m10_n_ff;
   logic m100_n_ff;
   logic m1000_n_ff;
   logic duplex_ff;
   logic transmit_ff;
   logic receive_ff;
   logic cview_div_ff;
   logic hold_ff;
   logic pdown_ff;
   prf_strap_t addr_ff;

   // Blanking reads the control flops, not the output pins, so the LEDs
   // go dark in the same cycle as phy_hold_reset and phy_power_down rise.
   wire blank_w = ctl_if.hold_reset || ctl_if.power_down;
   wire nxt_link_n = blank_w ? PRF_LED_N_DARK : host_led_n_w[PRF_LED_LINK_POS];
   wire nxt_m10_n = blank_w ? PRF_LED_N_DARK : host_led_n_w[PRF_LED_10M_POS];
   wire nxt_m100_n = blank_w ? PRF_LED_N_DARK : host_led_n_w[PRF_LED_100M_POS];
   wire nxt_m1000_n = blank_w ? PRF_LED_N_DARK : host_led_n_w[PRF_LED_1000M_POS];
   wire nxt_duplex = blank_w ? PRF_LED_DARK : duplex_w;
   wire nxt_transmit = blank_w ? PRF_LED_DARK : transmit_w;
   // Clock view shows clk_sys divided by two; the receive indication is lost while on
   wire nxt_receive = blank_w ? PRF_LED_DARK : (cview_en_w ? cview_div_ff : receive_w);
   wire nxt_addr = ctl_if.strap_capture;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         link_n_ff <= PRF_LED_N_DARK;
         m10_n_ff <= PRF_LED_N_DARK;
         m100_n_ff <= PRF_LED_N_DARK;
         m1000_n_ff <= PRF_LED_N_DARK;
      end else begin
         link_n_ff <= nxt_link_n;
         m10_n_ff <= nxt_m10_n;
         m100_n_ff <= nxt_m100_n;
         m1000_n_ff <= nxt_m1000_n;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         duplex_ff <= PRF_LED_DARK;
         transmit_ff <= PRF_LED_DARK;
         receive_ff <= PRF_LED_DARK;
      end else begin
         duplex_ff <= nxt_duplex;
         transmit_ff <= nxt_transmit;
         receive_ff <= nxt_receive;
      end
   end

   // Divider runs even while blanked, so a test header sees it at once
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cview_div_ff <= PRF_LVL_RST;
      end else begin
         cview_div_ff <= !cview_div_ff;
      end
   end

   // ****************************************
   // Reset, power-down and strap outputs
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hold_ff <= PRF_HOLD_RST;
         pdown_ff <= PRF_PDOWN_RST;
      end else begin
         hold_ff <= ctl_if.hold_reset;
         pdown_ff <= ctl_if.power_down;
      end
   end

   // Address keeps its value between captures, through reset pin and sleep
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         addr_ff <= PRF_STRAP_RST;
      end else if (nxt_addr) begin
         addr_ff <= strap_w;
      end
   end

   // ****************************************
   // Output pins
   // ****************************************
   assign port_a_link_led_n = link_n_ff;
   assign port_a_10m_led_n = m10_n_ff;
   assign port_a_100m_led_n = m100_n_ff;
   assign port_a_1000m_led_n = m1000_n_ff;
   assign port_a_full_duplex_led = duplex_ff;
   assign port_a_transmit_led = transmit_ff;
   assign port_a_receive_led = receive_ff;
   assign phy_hold_reset = hold_ff;
   assign phy_power_down = pdown_ff;
   assign mgmt_addr_bits_4_1 = addr_ff;

   // ****************************************
   // Checks
   // ****************************************
   host_led_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !blank_w |=> {port_a_1000m_led_n, port_a_100m_led_n, port_a_10m_led_n, port_a_link_led_n}
                   == $past(host_led_n_w))
      else $error("port A LED does not follow host LED");
   duplex_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !blank_w && duplex_w |=> port_a_full_duplex_led)
      else $error("duplex LED not lit");
   tx_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !blank_w |=> port_a_transmit_led == $past(transmit_w))
      else $error("transmit LED wrong");
   rx_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !blank_w && !cview_en_w |=> port_a_receive_led == $past(receive_w))
      else $error("receive LED wrong");
   cview_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!blank_w && cview_en_w)[*2] |=> port_a_receive_led != $past(port_a_receive_led))
      else $error("clock view not toggling");
   leds_dark_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      blank_w |=> {port_a_link_led_n, port_a_10m_led_n, port_a_100m_led_n, port_a_1000m_led_n} == 4'hF
                  && !port_a_full_duplex_led && !port_a_transmit_led && !port_a_receive_led)
      else $error("LED lit during reset or sleep");
   strap_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ctl_if.strap_capture |=> mgmt_addr_bits_4_1 == $past(strap_w))
      else $error("strap not captured");
   strap_steady_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !ctl_if.strap_capture |=> $stable(mgmt_addr_bits_4_1))
      else $error("address changed without capture");
   // Pin-level checks: hold and power-down pins against the control flops, then LED and divider checks
   hold_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'h1 |=> phy_hold_reset == $past(ctl_if.hold_reset))
      else $error("hold reset pin does not follow control");
   pdown_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'h1 |=> phy_power_down == $past(ctl_if.power_down))
      else $error("power down pin does not follow control");
   duplex_dark_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !blank_w && !duplex_w |=> !port_a_full_duplex_led)
      else $error("duplex LED lit in half duplex");
   pins_dark_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      phy_hold_reset || phy_power_down |-> port_a_link_led_n && port_a_10m_led_n && port_a_100m_led_n
         && port_a_1000m_led_n && !port_a_full_duplex_led && !port_a_transmit_led && !port_a_receive_led)
      else $error("LED lit while reset or power down pin high");
   cview_source_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !blank_w && cview_en_w |=> port_a_receive_led == $past(cview_div_ff))
      else $error("receive LED does not show clock view");
   cview_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      1'h1 |=> cview_div_ff != $past(cview_div_ff))
      else $error("clock view divider stopped");
endmodule : prf_led_top

/* prf_hub_model.sv */
`timescale 1ns/1ps
module prf_hub_model
   import prf_pkg::*;
#(
   parameter int LAG = 0
)
(
   input wire logic clk_sys,
   output logic [PRF_HOST_LED_W-1:0] host_led_n
);
   // ****************************************
   // Host LED pins, active low, dark at start
   // ****************************************
   initial host_led_n = 4'hF;
   // Slow host: changes land LAG+1 edges late, always just after an edge
   task automatic show(input logic [PRF_HOST_LED_W-1:0] led_n);
      repeat (LAG + 1) @(posedge clk_sys);
      #1;
      host_led_n = led_n;
   endtask : show
endmodule : prf_hub_model

/* prf_led_top_bench.sv */
`timescale 1ns/1ps
module prf_led_top_bench;
   import prf_pkg::*;
   logic clk_sys = 1'h0;
   logic rst_b = 1'h0;
   logic supply_ok_in = 1'h0;
   logic device_reset_low_in = 1'h0;
   logic sleep_request_in = 1'h0;
   logic [2:0] status_in = 3'h0;
   logic clock_view_en_in = 1'h0;
   prf_strap_t strap = 4'h0;
   logic [PRF_HOST_LED_W-1:0] host_led_n;
   logic [3:0] led_n;
   logic [2:0] led_hi;
   logic [1:0] ctl;
   prf_strap_t addr;
   logic cv;
   int errors = 0;
   int n_tests = 0;
   // ****************************************
   // Clock, host model and device
   // ****************************************
   initial forever #25 clk_sys = ~clk_sys;
   prf_hub_model #(.LAG(2)) hub (.clk_sys(clk_sys), .host_led_n(host_led_n));
   prf_led_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .supply_ok_in(supply_ok_in),
      .device_reset_low_in(device_reset_low_in), .sleep_request_in(sleep_request_in),
      .host_led_n_in(host_led_n), .phy_full_duplex_in(status_in[0]), .phy_transmit_in(status_in[1]),
      .phy_receive_in(status_in[2]), .clock_view_en_in(clock_view_en_in), .mgmt_addr_strap_in(strap),
      .port_a_link_led_n(led_n[0]), .port_a_10m_led_n(led_n[1]), .port_a_100m_led_n(led_n[2]),
      .port_a_1000m_led_n(led_n[3]), .port_a_full_duplex_led(led_hi[0]), .port_a_transmit_led(led_hi[1]),
      .port_a_receive_led(led_hi[2]), .phy_hold_reset(ctl[1]), .phy_power_down(ctl[0]),
      .mgmt_addr_bits_4_1(addr));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   // Drive and sample 1 ns after the edge, clear of the flops
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic dark;
      chk(led_n, 4'hF);
      chk({1'h0, led_hi}, 4'h0);
   endtask : dark
   task automatic close_out;
      $display("errors %0d, compares %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_power_up;
      dark();
      chk({2'h0, ctl}, 4'h2);
      strap = 4'hA;
      supply_ok_in = 1'h1;
      device_reset_low_in = 1'h1;
      step(6);
      chk({2'h0, ctl}, 4'h0);
      chk(addr, 4'hA);
   endtask : t_power_up
   task automatic t_leds;
      for (int i = 0; i < 4; i++) begin
         hub.show(~(4'h1 << i));
         step(4);
         chk(led_n, ~(4'h1 << i));
      end
      for (int i = 0; i < 3; i++) begin
         status_in = 3'h1 << i;
         step(4);
         chk({1'h0, led_hi}, 4'h1 << i);
      end
      status_in = 3'h0;
   endtask : t_leds
   task automatic t_clock_view;
      clock_view_en_in = 1'h1;
      step(4);
      cv = led_hi[2];
      step(1);
      chk({3'h0, led_hi[2]}, {3'h0, ~cv});
      clock_view_en_in = 1'h0;
   endtask : t_clock_view
   task automatic t_sleep;
      hub.show(4'h0);
      status_in = 3'h3;
      step(4);
      sleep_request_in = 1'h1;
      step(5);
      chk({2'h0, ctl}, 4'h1);
      dark();
      strap = 4'h5;
      step(2);
      sleep_request_in = 1'h0;
      step(6);
      chk(addr, 4'h5);
      chk(led_n, 4'h0);
      chk({1'h0, led_hi}, 4'h3);
   endtask : t_sleep
   task automatic t_reset_pin;
      device_reset_low_in = 1'h0;
      step(5);
      chk({2'h0, ctl}, 4'h2);
      dark();
      strap = 4'h3;
      step(2);
      device_reset_low_in = 1'h1;
      step(6);
      chk(addr, 4'h3);
      chk({2'h0, ctl}, 4'h0);
   endtask : t_reset_pin
   // Sleep during supply loss must not show as power-down
   task automatic t_supply;
      supply_ok_in = 1'h0;
      sleep_request_in = 1'h1;
      step(5);
      chk({2'h0, ctl}, 4'h2);
      dark();
      strap = 4'hC;
      step(2);
      supply_ok_in = 1'h1;
      sleep_request_in = 1'h0;
      step(6);
      chk(addr, 4'hC);
      chk({2'h0, ctl}, 4'h0);
   endtask : t_supply
   // ****************************************
   // Sequence and watchdog
   // ****************************************
   initial begin
      step(2);
      dark();
      chk(addr, 4'h0);
      step(2);
      rst_b = 1'h1;
      t_power_up();
      t_leds();
      t_clock_view();
      t_sleep();
      t_reset_pin();
      t_supply();
      close_out();
   end
   // Whole run needs about 100 cycles
   initial begin
      #150000;
      errors++;
      close_out();
   end
endmodule : prf_led_top_bench
